// ==== verilog/dsrp_pkg.sv ====
// package of constants and types for the self refresh and precharge block
package dsrp_pkg;
    localparam int          DSRP_BANKS       = 8;
    localparam int          DSRP_BA_W        = 3;
    // decoded command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0]  DSRP_CMD_ACT     = 4'h3;
    localparam logic [3:0]  DSRP_CMD_PRE     = 4'h2;
    localparam logic [3:0]  DSRP_CMD_REF     = 4'h1;
    localparam logic [3:0]  DSRP_CMD_RD      = 4'h5;
    localparam logic [3:0]  DSRP_CMD_WR      = 4'h4;
    // reset values
    localparam logic [7:0]  DSRP_BANK_RST    = 8'h00;
    // timing: clock rate and figures in their own units
    localparam int          DSRP_CLK_MHZ     = 50;
    localparam int          DSRP_TCKE_NS     = 40;
    localparam int          DSRP_REF_CYC     = 8;
    // longest time, rounded down, at least one cycle
    localparam int          DSRP_TCKE_RAW    = (DSRP_TCKE_NS * DSRP_CLK_MHZ) / 1000;
    localparam int          DSRP_TCKE_CYC    = (DSRP_TCKE_RAW < 1) ? 1 : DSRP_TCKE_RAW;
    localparam int          DSRP_CNT_W       = 8;
    typedef enum logic [1:0] {
        DSRP_ST_IDLE,
        DSRP_ST_SREF,
        DSRP_ST_EXIT
    } dsrp_state_t;
endpackage : dsrp_pkg

// ==== verilog/dsrp_edge.sv ====
// two-stage synchroniser with rising edge detect
`timescale 1ns/100ps
module dsrp_edge (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // asynchronous input
    input  wire logic async_in,
    // synchronised level and its rising edge
    output logic      sync_out,
    output logic      rise_out
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // meta_q is read only by sync_q
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // outputs from flip-flops plus edge term
    assign sync_out = sync_q;
    assign rise_out = sync_q & ~last_q;
endmodule : dsrp_edge

// ==== verilog/dsrp_core.sv ====
// DDR3 device-side precharge bank tracking and self refresh control
// Operation
// - A10 selects one bank or all
// - all-bank precharge ignores bank address
// - self refresh entry is REFRESH with CKE low
// - DLL off in self refresh, reset on exit
// - only CKE and reset matter in self refresh (here exit also waits for a CK rise)
// - internal refresh starts within CKE period
// - exit delays count from first CKE-high edge (not counted here; left to the controller)
`timescale 1ns/100ps
module dsrp_core
    import dsrp_pkg::*;
(
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // memory command pins, all asynchronous to core_clk
    input  wire logic                      mem_ck,
    input  wire logic                      mem_cke,
    input  wire logic                      mem_cs_n,
    input  wire logic                      mem_ras_n,
    input  wire logic                      mem_cas_n,
    input  wire logic                      mem_we_n,
    input  wire logic                      mem_a10,
    input  wire logic [dsrp_pkg::DSRP_BA_W-1:0] mem_ba,
    // device state
    output logic [dsrp_pkg::DSRP_BANKS-1:0] bank_open,
    output logic                      sref_active,
    output logic                      dll_enable,
    output logic                      dll_reset,
    output logic                      refresh_start,
    output logic                      cmd_error
);
    import dsrp_pkg::*;

    // synchronised pins; the CK level itself is never read, only its edge
    logic       ck_rise;
    logic       cke_s;
    logic [8:0] pin_m_q;
    logic [8:0] pin_s_q;

    // CK edge finder; a command is taken at the edge it reports
    dsrp_edge u_ck (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (mem_ck),
        .sync_out (),
        .rise_out (ck_rise)
    );

    // command pins pass two flip-flops before use, the same depth as CK,
    // so a command held round its CK rise is seen whole at the decoded edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_m_q <= 9'h1ff;
            pin_s_q <= 9'h1ff;
        end else begin
            pin_m_q <= {mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_a10, mem_ba};
            pin_s_q <= pin_m_q;
        end
    end

    // decoded command fields; pins and CK share the same two-flop delay, so
    // these fields line up with the CK edge found by u_ck
    logic [3:0]           cmd_w;
    logic                 a10_w;
    logic [DSRP_BA_W-1:0] ba_w;
    assign cmd_w = pin_s_q[7:4];
    assign a10_w = pin_s_q[3];
    assign ba_w  = pin_s_q[2:0];
    assign cke_s = pin_s_q[8];

    // state, bank table, counter
    // bank_q bit n high means bank n is open
    dsrp_state_t           st_q;
    dsrp_state_t           st_d;
    logic [DSRP_BANKS-1:0] bank_q;
    logic [DSRP_BANKS-1:0] bank_d;
    logic [DSRP_CNT_W-1:0] cnt_q;
    logic [DSRP_CNT_W-1:0] cnt_d;
    logic                  refp_q;
    logic                  dllr_q;
    logic                  err_q;

    // command strobes, each valid for the one cycle in which the CK edge
    // is reported, and state decodes, valid for as long as the state lasts
    logic in_idle;
    logic in_sref;
    logic live_w;
    logic is_act;
    logic is_pre;
    logic is_ref;
    logic is_rw;
    logic all_idle;
    logic sre_w;
    logic sre_ok;
    logic srx_w;
    logic cnt_end;
    logic rw_idle;

    // state decodes
    assign in_idle  = (st_q == DSRP_ST_IDLE);
    assign in_sref  = (st_q == DSRP_ST_SREF);

    // a command counts only on a CK edge in the idle state
    assign live_w   = ck_rise & in_idle;
    assign is_act   = live_w & (cmd_w == DSRP_CMD_ACT);
    assign is_pre   = live_w & (cmd_w == DSRP_CMD_PRE);
    assign is_ref   = live_w & (cmd_w == DSRP_CMD_REF);
    assign is_rw    = live_w & ((cmd_w == DSRP_CMD_RD) | (cmd_w == DSRP_CMD_WR));
    assign all_idle = (bank_q == DSRP_BANK_RST);
    // entry is a REFRESH sampled with CKE low
    assign sre_w    = is_ref & ~cke_s;
    // entry accepted only with all banks idle
    assign sre_ok   = sre_w & all_idle;
    // exit counted at first CK edge with CKE high
    assign srx_w    = ck_rise & cke_s & in_sref;
    // counter at its last step before an internal refresh
    assign cnt_end  = (cnt_q == DSRP_CNT_W'(1));
    // read or write aimed at a bank that is not open
    assign rw_idle  = is_rw & ~bank_q[ba_w];

    // bank open/idle table, one entry per bank; precharge and activate
    // are exclusive codes, the close term is simply tested first
    genvar gi;
    generate
        for (gi = 0; gi < DSRP_BANKS; gi++) begin : g_bank
            logic sel;
            logic close_b;
            logic open_b;
            assign sel     = (ba_w == DSRP_BA_W'(gi));
            // single bank by address, all by A10
            // bank address ignored when A10 is high
            assign close_b = is_pre & (a10_w | sel);
            assign open_b  = is_act & sel;
            assign bank_d[gi] = close_b ? 1'b0 : (open_b ? 1'b1 : bank_q[gi]);
        end
    endgenerate

    // next state and refresh counter
    // the counter starts at the CKE pulse period on entry, so the first
    // internal refresh lands inside it; it then reloads for a steady repeat
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            DSRP_ST_IDLE: begin
                // an entry with an open bank is refused and flagged
                if (sre_ok) begin
                    st_d  = DSRP_ST_SREF;
                    cnt_d = DSRP_CNT_W'(DSRP_TCKE_CYC);
                end
            end
            DSRP_ST_SREF: begin
                // only CKE, taken at a CK edge, observed while in self refresh
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    cnt_d = DSRP_CNT_W'(DSRP_REF_CYC);
                end
                // leave on the first CK edge that sees CKE high
                if (srx_w) begin
                    st_d = DSRP_ST_EXIT;
                end
            end
            DSRP_ST_EXIT: begin
                // one cycle for the DLL reset pulse; commands here are dropped,
                // as only NOP or deselect may stand in the exit time
                st_d = DSRP_ST_IDLE;
            end
            default: begin
                // an unused encoding falls back to idle
                st_d = DSRP_ST_IDLE;
            end
        endcase
    end

    // registers; the exit delays are the controller's to keep, so nothing
    // here holds back commands once the exit cycle is over; a user who
    // needs that guard must add it on the controller side
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q   <= DSRP_ST_IDLE;
            bank_q <= DSRP_BANK_RST;
            cnt_q  <= '0;
            refp_q <= 1'b0;
            dllr_q <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            // bank table follows ACT and PRE
            bank_q <= bank_d;
            cnt_q  <= cnt_d;
            refp_q <= in_sref & cnt_end;
            dllr_q <= srx_w;
            // flag read/write to idle bank, entry with open bank
            err_q  <= rw_idle | (sre_w & ~all_idle);
        end
    end

    // DLL disabled while in self refresh, back on from the exit cycle
    assign dll_enable    = ~in_sref;
    assign dll_reset     = dllr_q;
    // state and table straight from their registers
    assign sref_active   = in_sref;
    assign bank_open     = bank_q;
    // pulses, one cycle each
    assign refresh_start = refp_q;
    assign cmd_error     = err_q;
endmodule : dsrp_core

// ==== test/dsrp_assertions.sv ====
// assertions on the core's outputs
`timescale 1ns/100ps
module dsrp_assertions (
    // watched ports
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       mem_cke,
    input wire logic [7:0] bank_open,
    input wire logic       sref_active,
    input wire logic       dll_enable,
    input wire logic       dll_reset,
    input wire logic       refresh_start
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_DLL: assert property (dll_reset |-> $past(sref_active) && dll_enable)
        else $error("dll reset outside exit");
    AST_DRST: assert property ($fell(sref_active) |-> dll_reset) else $error("no reset");
    AST_EXIT: assert property ($fell(sref_active) |-> mem_cke) else $error("exit");
    AST_ENTRY: assert property ($rose(sref_active) |-> !mem_cke) else $error("entry");
    AST_FROZEN: assert property (sref_active |-> $stable(bank_open)) else $error("moved");
    AST_IDLE: assert property ($rose(sref_active) |-> $past(bank_open) == 8'h00)
        else $error("open bank");
    AST_REF: assert property ($rose(sref_active) |-> ##[0:2] refresh_start)
        else $error("late refresh");
    AST_ONE: assert property (refresh_start |-> $past(sref_active))
        else $error("refresh outside self refresh");
    cover property ($rose(sref_active));
    cover property ($fell(sref_active));
    cover property (dll_reset);
    cover property (refresh_start);
endmodule : dsrp_assertions
bind dsrp_core dsrp_assertions chk (
    .core_clk      (core_clk),
    .rst           (rst),
    .mem_cke       (mem_cke),
    .bank_open     (bank_open),
    .sref_active   (sref_active),
    .dll_enable    (dll_enable),
    .dll_reset     (dll_reset),
    .refresh_start (refresh_start)
);

// ==== test/dsrp_ctrl_model.sv ====
// controller model, one command per mem_ck period
`timescale 1ns/100ps
module dsrp_ctrl_model (
    // clock and command pins
    input  wire logic  core_clk,
    output logic       mem_ck,
    output logic       mem_cke,
    output logic       mem_cs_n,
    output logic       mem_ras_n,
    output logic       mem_cas_n,
    output logic       mem_we_n,
    output logic       mem_a10,
    output logic [2:0] mem_ba
);
    // no termination pin is driven: termination stays off throughout
    // idle: ck low, cke high, deselect
    initial {mem_ck, mem_cke} = 2'h1;
    initial {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_a10, mem_ba} = 8'hf0;
    // pins held round the ck rise, then deselect
    // one steady 160 ns ck period per call; called at a negedge
    task automatic cmd(input logic [8:0] w);
        {mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_a10, mem_ba} = w;
        mem_ck = 1'b0;
        repeat (4) @(negedge core_clk);
        mem_ck = 1'b1;
        repeat (2) @(negedge core_clk);
        {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_a10, mem_ba} = {4'hf, ~w[3:0]};
        repeat (2) @(negedge core_clk);
    endtask : cmd
endmodule : dsrp_ctrl_model

// ==== test/dsrp_core_tb_top.sv ====
// bench for precharge and self refresh
`timescale 1ns/100ps
module dsrp_core_tb_top;
    import dsrp_pkg::*;
    logic       core_clk = 1'b0, rst = 1'b1, mem_ck, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n;
    logic       mem_we_n, mem_a10, sref_active, dll_enable, dll_reset, refresh_start, cmd_error;
    logic [2:0] mem_ba, seen = 3'h0;
    logic       seen_clr = 1'b0;
    logic [7:0] bank_open;
    int         n_errors = 0, n_compared = 0;
    dsrp_core dut (
        .core_clk      (core_clk),
        .rst           (rst),
        .mem_ck        (mem_ck),
        .mem_cke       (mem_cke),
        .mem_cs_n      (mem_cs_n),
        .mem_ras_n     (mem_ras_n),
        .mem_cas_n     (mem_cas_n),
        .mem_we_n      (mem_we_n),
        .mem_a10       (mem_a10),
        .mem_ba        (mem_ba),
        .bank_open     (bank_open),
        .sref_active   (sref_active),
        .dll_enable    (dll_enable),
        .dll_reset     (dll_reset),
        .refresh_start (refresh_start),
        .cmd_error     (cmd_error)
    );
    dsrp_ctrl_model m (
        .core_clk  (core_clk),
        .mem_ck    (mem_ck),
        .mem_cke   (mem_cke),
        .mem_cs_n  (mem_cs_n),
        .mem_ras_n (mem_ras_n),
        .mem_cas_n (mem_cas_n),
        .mem_we_n  (mem_we_n),
        .mem_a10   (mem_a10),
        .mem_ba    (mem_ba)
    );
    // clock
    initial forever #10 core_clk = ~core_clk;
    // catch error, refresh, dll reset pulses; seen_clr empties the catch
    always @(posedge core_clk) begin
        if (seen_clr) seen <= 3'h0;
        else seen <= seen | {cmd_error, refresh_start, dll_reset};
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) n_errors++;
        if (got !== exp) $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic t_bank;
        for (int i = 0; i < 8; i++) m.cmd({1'b1, DSRP_CMD_ACT, 1'b0, i[2:0]});
        chk(bank_open, 8'hff);
        m.cmd({1'b1, DSRP_CMD_PRE, 4'h5});
        chk(bank_open, 8'hdf);
        m.cmd({1'b1, DSRP_CMD_PRE, 4'hd});
        chk(bank_open, 8'h00);
        m.cmd({1'b1, DSRP_CMD_RD, 4'h5});
        chk({5'h00, seen}, 8'h04);
        $display("t_bank done");
    endtask : t_bank
    task automatic t_sref;
        m.cmd({1'b1, DSRP_CMD_ACT, 4'h2});
        seen_clr = 1'b1;
        @(negedge core_clk);
        seen_clr = 1'b0;
        m.cmd({1'b0, DSRP_CMD_REF, 4'h0});
        chk({4'h0, seen, sref_active}, 8'h08);
        m.cmd({1'b1, DSRP_CMD_PRE, 4'h2});
        m.cmd({1'b0, DSRP_CMD_REF, 4'h0});
        chk({6'h00, sref_active, dll_enable}, 8'h02);
        m.cmd({1'b0, DSRP_CMD_ACT, 4'h1});
        chk({bank_open[4:0], seen}, 8'h06);
        // no write, DLL-locked command or termination follows exit
        m.cmd({1'b1, 4'hf, 4'h0});
        chk({5'h00, seen[0], sref_active, dll_enable}, 8'h05);
        $display("t_sref done");
    endtask : t_sref
    // reset, then the tests
    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_bank;
        t_sref;
        complete_run;
    end
    // watchdog: the tests need about 2,900 ns, the limit is well above that
    initial begin
        #20000 n_errors++;
        complete_run;
    end
endmodule : dsrp_core_tb_top
